/* nvm_write_verifier.sv */
// Read-back check after every nonvolatile memory write
`timescale 1ns/1ps
module nvm_write_verifier (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       nvm_write_done,
  input  wire logic [7:0] nvm_write_data,
  input  wire logic       nvm_readback_valid,
  input  wire logic [7:0] nvm_readback_data,
  output logic            readback_request,
  output logic            mismatch
);
  logic [7:0] expect_reg;
  logic       pending_reg;
  logic       req_reg;
  logic       miss_reg;
  logic       compare_now;

  assign compare_now = pending_reg && nvm_readback_valid;

  // Latch written data, request read-back, compare on return
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      expect_reg  <= 8'h00;
      pending_reg <= 1'b0;
      req_reg     <= 1'b0;
      miss_reg    <= 1'b0;
    end else begin
      req_reg  <= nvm_write_done;
      miss_reg <= compare_now && (nvm_readback_data != expect_reg);
      if (nvm_write_done) begin
        expect_reg  <= nvm_write_data;
        pending_reg <= 1'b1;
      end else if (compare_now) begin
        pending_reg <= 1'b0;
      end
    end
  end

  assign readback_request = req_reg;
  assign mismatch         = miss_reg;
endmodule : nvm_write_verifier

/* sensor_cal_assertions.sv */
// Concurrent checks on the calibration and error status ports
`timescale 1ns/1ps
module sensor_cal_assertions #(
  parameter logic [31:0] HOLD_CYCLES = sensor_cal_pkg::CAL_HOLD_CYC
) (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        background_cal_switch_n,
  input wire logic [15:0] reading_ppm,
  input wire logic        ref_write,
  input wire logic [15:0] ref_write_data,
  input wire logic        fatal_fault,
  input wire logic        offset_reg_fault,
  input wire logic        output_fault,
  input wire logic        nvm_write_done,
  input wire logic        nvm_readback_request,
  input wire logic        background_calibration_cmd,
  input wire logic        cal_apply,
  input wire logic [15:0] zero_constant,
  input wire logic [15:0] cal_reference,
  input wire logic [7:0]  uart_err_read_data,
  input wire logic [7:0]  i2c_err_read_data,
  input wire logic        status_ok
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Error byte, status pin and read fronts
  a_status_low_fault: assert property (status_ok == (uart_err_read_data == 8'h00))
    else $error("status pin disagrees with error byte");
  a_fronts_agree: assert property (i2c_err_read_data == uart_err_read_data)
    else $error("serial fronts show different bytes");
  a_reserved_bit_clear: assert property (!uart_err_read_data[7])
    else $error("reserved error bit set");
  a_fatal_bit_set: assert property (fatal_fault |-> ##2 uart_err_read_data[0])
    else $error("fatal bit not set");
  a_output_bit_set: assert property (output_fault |-> ##2 uart_err_read_data[3])
    else $error("output fault bit not set");
  a_offset_bit_clears: assert property (!offset_reg_fault [*3] |-> !uart_err_read_data[1])
    else $error("offset bit stays after fault gone");
  // Reference, memory check and calibration
  a_ref_load: assert property (ref_write |=> cal_reference == $past(ref_write_data))
    else $error("reference not loaded");
  a_readback_request: assert property (nvm_write_done |=> nvm_readback_request)
    else $error("no read back after memory write");
  a_hold_before_cmd: assert property ($rose(background_calibration_cmd) |->
    !$past(background_cal_switch_n, 8)) else $error("calibration started without long closure");
  a_cal_step_value: assert property (cal_apply |-> zero_constant == 16'($past(zero_constant) +
    ($past(background_calibration_cmd) ? $past(cal_reference) : 16'h0000) - $past(reading_ppm)))
    else $error("zero constant step wrong");
endmodule : sensor_cal_assertions

bind sensor_calibration_and_error_status sensor_cal_assertions #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .background_cal_switch_n(background_cal_switch_n),
  .reading_ppm(reading_ppm), .ref_write(ref_write), .ref_write_data(ref_write_data),
  .fatal_fault(fatal_fault), .offset_reg_fault(offset_reg_fault), .output_fault(output_fault),
  .nvm_write_done(nvm_write_done), .nvm_readback_request(nvm_readback_request),
  .background_calibration_cmd(background_calibration_cmd), .cal_apply(cal_apply),
  .zero_constant(zero_constant), .cal_reference(cal_reference),
  .uart_err_read_data(uart_err_read_data), .i2c_err_read_data(i2c_err_read_data),
  .status_ok(status_ok));

/* sensor_cal_pkg.sv */
// Constants shared by the calibration and error status block
package sensor_cal_pkg;
  // Clock and switch hold time
  localparam longint CLK_HZ          = 64'd250_000_000;
  localparam longint CAL_HOLD_S      = 64'd8;
  localparam longint CAL_HOLD_CYC_L  = CAL_HOLD_S * CLK_HZ;
  localparam logic [31:0] CAL_HOLD_CYC = CAL_HOLD_CYC_L[31:0];
  // Calibration reference values in ppm
  localparam logic [15:0] REF_BG_RESET = 16'h0190;
  localparam logic [15:0] REF_ZERO     = 16'h0000;
  localparam logic [15:0] ZERO_CONST_RESET = 16'h0000;
  // Probe dynamic range limits
  localparam logic [15:0] PROBE_MIN    = 16'h0000;
  localparam logic [15:0] PROBE_MAX    = 16'h1388;
  // Error byte bit positions
  localparam int ERR_FATAL   = 0;
  localparam int ERR_OFFSET  = 1;
  localparam int ERR_ALGO    = 2;
  localparam int ERR_OUTPUT  = 3;
  localparam int ERR_DIAG    = 4;
  localparam int ERR_RANGE   = 5;
  localparam int ERR_MEMORY  = 6;
  localparam logic [7:0] ERR_RESET     = 8'h00;
  localparam logic [7:0] ERR_AUTO_MASK = 8'h22;
  localparam logic [7:0] ERR_USED_MASK = 8'h7F;
  // Power-up self-test timeout in cycles
  localparam logic [15:0] SELFTEST_TIMEOUT = 16'h0FA0;
  // Self-test sequencer states, Gray along the usual path
  typedef enum logic [1:0] {
    ST_START = 2'b00,
    ST_WAIT  = 2'b01,
    ST_DONE  = 2'b11
  } selftest_state_t;
endpackage : sensor_cal_pkg

/* sensor_calibration_and_error_status.sv */
// Calibration switches, self-diagnostics and error byte with status pin
`timescale 1ns/1ps
module sensor_calibration_and_error_status #(
  parameter logic [31:0] HOLD_CYCLES = sensor_cal_pkg::CAL_HOLD_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        background_cal_switch_n,
  input  wire logic        zero_cal_switch_n,
  input  wire logic        reading_valid,
  input  wire logic [15:0] reading_ppm,
  input  wire logic        ref_write,
  input  wire logic [15:0] ref_write_data,
  input  wire logic        uart_err_write,
  input  wire logic [7:0]  uart_err_write_data,
  input  wire logic        probe_valid,
  input  wire logic [15:0] probe_value,
  input  wire logic        fatal_fault,
  input  wire logic        offset_reg_fault,
  input  wire logic        nvm_config_invalid,
  input  wire logic        output_fault,
  input  wire logic        selfdiag_fault,
  input  wire logic        selftest_done,
  input  wire logic        selftest_pass,
  input  wire logic        nvm_write_done,
  input  wire logic [7:0]  nvm_write_data,
  input  wire logic        nvm_readback_valid,
  input  wire logic [7:0]  nvm_readback_data,
  output logic             selftest_start,
  output logic             selftest_busy,
  output logic             nvm_readback_request,
  output logic             background_calibration_cmd,
  output logic             zero_calibration_cmd,
  output logic             cal_apply,
  output logic [15:0]      zero_constant,
  output logic [15:0]      cal_reference,
  output logic [7:0]       uart_err_read_data,
  output logic [7:0]       i2c_err_read_data,
  output logic             status_ok
);

  // Qualified switch levels
  logic bg_held;
  logic zero_held;

  // Calibration registers
  logic [15:0] ref_reg;
  logic [15:0] ref_next;
  logic [15:0] zero_const_reg;
  logic [15:0] zero_const_next;
  logic        apply_reg;
  logic        cal_step;
  logic [15:0] target_ppm;
  logic [15:0] correction;

  // Self-test sequencer
  sensor_cal_pkg::selftest_state_t st_reg;
  sensor_cal_pkg::selftest_state_t st_next;
  logic [15:0] st_timer_reg;
  logic [15:0] st_timer_next;
  logic        st_timeout;
  logic        st_fail;

  // Range check and memory check
  logic        range_viol;
  logic        range_bad_reg;
  logic        mem_mismatch;

  // Error byte
  logic [7:0]  sticky_reg;
  logic [7:0]  sticky_next;
  logic [7:0]  sticky_set;
  logic [7:0]  sticky_keep;
  logic [7:0]  auto_bits;
  logic [7:0]  err_byte;
  logic [7:0]  err_out_reg;
  logic        status_reg;

  // Range test used for probe samples
  function automatic logic in_range(input logic [15:0] value);
    in_range = (value >= sensor_cal_pkg::PROBE_MIN) && (value <= sensor_cal_pkg::PROBE_MAX);
  endfunction : in_range

  // Background calibration contact qualifier
  switch_hold_qualifier #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_bg_switch (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .contact_n   (background_cal_switch_n),
    .held_active (bg_held)
  );

  // Zero calibration contact qualifier
  switch_hold_qualifier #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_zero_switch (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .contact_n   (zero_cal_switch_n),
    .held_active (zero_held)
  );

  // Memory write read-back verifier
  nvm_write_verifier u_nvm_verify (
    .clk_sys            (clk_sys),
    .rst                (rst),
    .nvm_write_done     (nvm_write_done),
    .nvm_write_data     (nvm_write_data),
    .nvm_readback_valid (nvm_readback_valid),
    .nvm_readback_data  (nvm_readback_data),
    .readback_request   (nvm_readback_request),
    .mismatch           (mem_mismatch)
  );

  // Calibration target selection, background switch has priority
  assign target_ppm = bg_held ? ref_reg : sensor_cal_pkg::REF_ZERO;
  assign cal_step   = reading_valid && (bg_held || zero_held);
  assign correction = 16'(target_ppm - reading_ppm);
  assign zero_const_next = cal_step ? 16'(zero_const_reg + correction) : zero_const_reg;
  assign ref_next   = ref_write ? ref_write_data : ref_reg;

  // Reference and zero constant storage
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ref_reg        <= sensor_cal_pkg::REF_BG_RESET;
      zero_const_reg <= sensor_cal_pkg::ZERO_CONST_RESET;
      apply_reg      <= 1'b0;
    end else begin
      ref_reg        <= ref_next;
      zero_const_reg <= zero_const_next;
      apply_reg      <= cal_step;
    end
  end

  // Power-up self-test sequencing
  assign st_timeout = (st_timer_reg >= sensor_cal_pkg::SELFTEST_TIMEOUT);
  always_comb begin
    st_next       = st_reg;
    st_timer_next = st_timer_reg;
    case (st_reg)
      sensor_cal_pkg::ST_START: begin
        st_next       = sensor_cal_pkg::ST_WAIT;
        st_timer_next = 16'h0000;
      end
      sensor_cal_pkg::ST_WAIT: begin
        st_timer_next = 16'(st_timer_reg + 16'h0001);
        if (selftest_done || st_timeout) begin
          st_next = sensor_cal_pkg::ST_DONE;
        end
      end
      sensor_cal_pkg::ST_DONE: begin
        st_next = sensor_cal_pkg::ST_DONE;
      end
      default: begin
        st_next = sensor_cal_pkg::ST_START;
      end
    endcase
  end

  // Self-test fails on a bad result or no answer in time
  assign st_fail = (st_reg == sensor_cal_pkg::ST_WAIT) &&
                   ((selftest_done && !selftest_pass) || (!selftest_done && st_timeout));

  // Self-test state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_reg       <= sensor_cal_pkg::ST_START;
      st_timer_reg <= 16'h0000;
    end else begin
      st_reg       <= st_next;
      st_timer_reg <= st_timer_next;
    end
  end

  // Probe range check, result held until next sample
  assign range_viol = probe_valid && !in_range(probe_value);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      range_bad_reg <= 1'b0;
    end else if (probe_valid) begin
      range_bad_reg <= range_viol;
    end
  end

  // Self-clearing bits follow their live condition
  assign auto_bits = {1'b0, 1'b0, range_bad_reg, 1'b0,
                      1'b0, 1'b0, offset_reg_fault, 1'b0};

  // Sticky fault sources by bit position
  assign sticky_set = {1'b0,
                       mem_mismatch,
                       1'b0,
                       selfdiag_fault || st_fail,
                       output_fault,
                       nvm_config_invalid,
                       1'b0,
                       fatal_fault};

  // Host overwrite replaces sticky bits, a new fault wins over the clear
  assign sticky_keep = uart_err_write ?
                       (uart_err_write_data & ~sensor_cal_pkg::ERR_AUTO_MASK) :
                       sticky_reg;
  assign sticky_next = (sticky_keep | sticky_set) &
                       sensor_cal_pkg::ERR_USED_MASK & ~sensor_cal_pkg::ERR_AUTO_MASK;

  // Sticky error storage, cleared only by overwrite or reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sticky_reg <= sensor_cal_pkg::ERR_RESET;
    end else begin
      sticky_reg <= sticky_next;
    end
  end

  // All faults merge into one byte
  assign err_byte = (sticky_reg | auto_bits) & sensor_cal_pkg::ERR_USED_MASK;

  // Registered read copy and status pin
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      err_out_reg <= sensor_cal_pkg::ERR_RESET;
      status_reg  <= 1'b1;
    end else begin
      err_out_reg <= err_byte;
      status_reg  <= (err_byte == 8'h00);
    end
  end

  // Output drive
  assign selftest_start             = (st_reg == sensor_cal_pkg::ST_START);
  assign selftest_busy              = (st_reg != sensor_cal_pkg::ST_DONE);
  assign background_calibration_cmd = bg_held;
  assign zero_calibration_cmd       = zero_held && !bg_held;
  assign cal_apply                  = apply_reg;
  assign zero_constant              = zero_const_reg;
  assign cal_reference              = ref_reg;
  assign uart_err_read_data         = err_out_reg;
  assign i2c_err_read_data          = err_out_reg;
  assign status_ok                  = status_reg;

endmodule : sensor_calibration_and_error_status

/* sensor_calibration_and_error_status_tb.sv */
// Self-checking bench for the calibration and error status block
`timescale 1ns/1ps
module sensor_calibration_and_error_status_tb;
  localparam logic [31:0] HOLD = 32'h0000_0014;
  logic        clk_sys, rst, bg_n, zero_n, rv, ref_write, clear_req, uart_wr, probe_valid;
  logic        fatal, offset, cfg_bad, out_fault, diag, st_done, st_pass, wr_done, rb_valid;
  logic        st_start, st_busy, rb_req, bg_cmd, zero_cmd, cal_apply, status_ok;
  logic [15:0] rppm, ref_data, probe_value, zc, cal_ref;
  logic [7:0]  uart_wd, wr_data, rb_data, uart_rd, i2c_rd;
  int          errors, checked, n;

  sensor_calibration_and_error_status #(.HOLD_CYCLES(HOLD)) dut (
    .clk_sys(clk_sys), .rst(rst), .background_cal_switch_n(bg_n), .zero_cal_switch_n(zero_n),
    .reading_valid(rv), .reading_ppm(rppm), .ref_write(ref_write), .ref_write_data(ref_data),
    .uart_err_write(uart_wr), .uart_err_write_data(uart_wd), .probe_valid(probe_valid),
    .probe_value(probe_value), .fatal_fault(fatal), .offset_reg_fault(offset),
    .nvm_config_invalid(cfg_bad), .output_fault(out_fault), .selfdiag_fault(diag),
    .selftest_done(st_done), .selftest_pass(st_pass), .nvm_write_done(wr_done),
    .nvm_write_data(wr_data), .nvm_readback_valid(rb_valid), .nvm_readback_data(rb_data),
    .selftest_start(st_start), .selftest_busy(st_busy), .nvm_readback_request(rb_req),
    .background_calibration_cmd(bg_cmd), .zero_calibration_cmd(zero_cmd),
    .cal_apply(cal_apply), .zero_constant(zc), .cal_reference(cal_ref),
    .uart_err_read_data(uart_rd), .i2c_err_read_data(i2c_rd), .status_ok(status_ok));

  status_host host (.clk_sys(clk_sys), .clear_req(clear_req), .uart_err_write(uart_wr),
    .uart_err_write_data(uart_wd));

  // Clock, 4 ns period
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task tick(input int c);
    repeat (c) @(posedge clk_sys);
  endtask : tick

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task wrap_up;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // Bounded wait for a calibration command level
  task wait_cmd(input logic bg, input logic lvl);
    n = 0;
    while (((bg ? bg_cmd : zero_cmd) !== lvl) && n < 200) begin
      tick(1);
      #1;
      n++;
    end
    if (n >= 200) begin
      errors++;
      $display("MISMATCH t=%0t calibration command wait timed out", $time);
      wrap_up();
    end
  endtask : wait_cmd

  task clear_byte;
    clear_req <= 1'b1;
    tick(1);
    clear_req <= 1'b0;
    tick(4);
    #1;
  endtask : clear_byte

  task t_selftest;
    tick(1);
    st_done <= 1'b1;
    st_pass <= 1'b1;
    tick(1);
    st_done <= 1'b0;
    tick(4);
    #1;
    chk(16'(st_busy), 16'h0000);
    chk(16'(uart_rd), 16'h0000);
  endtask : t_selftest

  task t_sticky;
    tick(1);
    fatal <= 1'b1;
    cfg_bad <= 1'b1;
    out_fault <= 1'b1;
    diag <= 1'b1;
    offset <= 1'b1;
    tick(1);
    {fatal, cfg_bad, out_fault, diag} <= 4'h0;
    tick(3);
    #1;
    chk(16'(uart_rd), 16'h001F);
    chk(16'(i2c_rd), 16'h001F);
    chk(16'(status_ok), 16'h0000);
    offset <= 1'b0;
    tick(4);
    #1;
    chk(16'(uart_rd), 16'h001D);
    clear_byte();
    chk(16'(uart_rd), 16'h0000);
    chk(16'(status_ok), 16'h0001);
  endtask : t_sticky

  task t_range;
    probe_valid <= 1'b1;
    probe_value <= 16'h1389;
    tick(1);
    probe_valid <= 1'b0;
    tick(3);
    #1;
    chk(16'(uart_rd), 16'h0020);
    probe_valid <= 1'b1;
    probe_value <= 16'h1388;
    tick(1);
    probe_valid <= 1'b0;
    tick(3);
    #1;
    chk(16'(uart_rd), 16'h0000);
  endtask : t_range

  // Memory write with one read back of the given byte
  task t_memory(input logic [7:0] rd, input logic [15:0] exp);
    wr_done <= 1'b1;
    wr_data <= 8'h5A;
    tick(1);
    wr_done <= 1'b0;
    #1;
    chk(16'(rb_req), 16'h0001);
    tick(1);
    rb_valid <= 1'b1;
    rb_data <= rd;
    tick(1);
    rb_valid <= 1'b0;
    rb_data <= ~rd;
    tick(4);
    #1;
    chk(16'(uart_rd), exp);
    clear_byte();
  endtask : t_memory

  task t_cal;
    ref_write <= 1'b1;
    ref_data <= 16'h01F4;
    tick(1);
    ref_write <= 1'b0;
    bg_n <= 1'b0;
    tick(12);
    bg_n <= 1'b1;
    tick(4);
    #1;
    chk(16'(bg_cmd), 16'h0000);
    chk(cal_ref, 16'h01F4);
    bg_n <= 1'b0;
    wait_cmd(1'b1, 1'b1);
    chk(16'(n >= HOLD), 16'h0001);
    rv <= 1'b1;
    rppm <= 16'h0100;
    tick(1);
    rppm <= 16'h0200;
    tick(1);
    rv <= 1'b0;
    tick(2);
    #1;
    chk(zc, 16'h00E8);
    bg_n <= 1'b1;
    wait_cmd(1'b1, 1'b0);
    zero_n <= 1'b0;
    rv <= 1'b1;
    rppm <= 16'h0300;
    tick(1);
    rv <= 1'b0;
    wait_cmd(1'b0, 1'b1);
    chk(zc, 16'h00E8);
    rv <= 1'b1;
    rppm <= 16'h0008;
    tick(1);
    rv <= 1'b0;
    tick(2);
    #1;
    chk(zc, 16'h00E0);
    zero_n <= 1'b1;
    wait_cmd(1'b0, 1'b0);
  endtask : t_cal

  // Main sequence
  initial begin
    errors = 0;
    checked = 0;
    {rst, bg_n, zero_n} = 3'h7;
    {rv, ref_write, clear_req, probe_valid, fatal, offset, cfg_bad} = 7'h00;
    {out_fault, diag, st_done, st_pass, wr_done, rb_valid} = 6'h00;
    {rppm, ref_data, probe_value, wr_data, rb_data} = '0;
    tick(5);
    #1;
    chk(16'(st_start), 16'h0001);
    chk(cal_ref, 16'h0190);
    chk(16'(status_ok), 16'h0001);
    tick(1);
    rst <= 1'b0;
    t_selftest();
    t_sticky();
    t_range();
    t_memory(8'h5B, 16'h0040);
    t_memory(8'h5A, 16'h0000);
    t_cal();
    wrap_up();
  end
endmodule : sensor_calibration_and_error_status_tb

/* status_host.sv */
// Host model that overwrites the error byte over the serial front
`timescale 1ns/1ps
module status_host (
  input  wire logic  clk_sys,
  input  wire logic  clear_req,
  output logic       uart_err_write = 1'b0,
  output logic [7:0] uart_err_write_data = 8'hA5
);
  // One-cycle overwrite with zero; idle data keeps toggling
  always @(posedge clk_sys) begin
    uart_err_write <= clear_req;
    uart_err_write_data <= clear_req ? 8'h00 : ~uart_err_write_data;
  end
endmodule : status_host

/* switch_hold_qualifier.sv */
// Synchronises an active-low contact and qualifies a long closure
`timescale 1ns/1ps
module switch_hold_qualifier #(
  parameter logic [31:0] HOLD_CYCLES = sensor_cal_pkg::CAL_HOLD_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic contact_n,
  output logic      held_active
);
  logic        sync1_reg;
  logic        sync2_reg;
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic        closed;
  logic        reached;

  // Two-stage synchroniser on the raw pin
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else begin
      sync1_reg <= contact_n;
      sync2_reg <= sync1_reg;
    end
  end

  // Contact to ground reads as active
  assign closed     = ~sync2_reg;
  assign reached    = (count_reg >= HOLD_CYCLES);
  // Restart from zero whenever the contact opens
  assign count_next = !closed ? 32'h0000_0000 :
                      reached ? count_reg : count_reg + 32'h0000_0001;

  // Closure duration counter
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_reg <= 32'h0000_0000;
    end else begin
      count_reg <= count_next;
    end
  end

  // Active only after full hold time and while still closed
  assign held_active = closed && reached;
endmodule : switch_hold_qualifier
